// file: design/interprocessor_doorbell_dialogue.sv
/*
 interprocessor doorbell and host bus dialogue: decodes host status write,
 status read and interrupt dialogue cycles, keeps both request flags, answers
 the peripheral register port and drives the host bus through the select gates.
 assumes one clock, host and peripheral strobes synchronous to it, and slot
 wiring inputs that are stable while out of reset.
*/
// Implementation choices: the strobed register port and the register offsets.
// Behaviour
// [R01] host interrupts peripheral with bit 23
// [R02] status write: select, function, then host_cycle_strobe
// [R03] status write bit 23 sets peripheral flag
// [R04] peripheral flag drives bus request out
// [R05] acknowledge and transfer after capture
// [R06] bus request raises peripheral interrupt
// [R07] device code 200 plus four per slot
// [R08] physical number compared in interrupt dialogues only
// [R09] status read uses full device code
// [R10] status read enables mixer select one
// [R11] status on bits 20-22, 26, 27, 29-35
// [R12] fixed vector and register base per slot
// [R13] codes come from slot wiring inputs
// [R14] slave sync releases busy, vector, line
// [R15] z with opword send or x
// [R16] x on loopback, diagnostic, examine read
// [R17] y with x, a, hostbound data
// [R18] data disable forces all drivers low
// [R19] peripheral clears its flag with bit 10
// [R20] peripheral bit 08 sets host flag
// [R21] host bit 26 clears host flag
// [R22] flags hold until owner clears them
`timescale 1ns/100ps
`include "doorbell_defs.svh"
module interprocessor_doorbell_dialogue (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire doorbell_pkg::host_cmd_s hostCmd,
   input wire logic [0:35] hostDataIn,
   input wire logic [0:35] ebufData,
   input wire doorbell_pkg::bus_ctl_s busCtl,
   input wire logic [1:0] slotNum,
   input wire logic [0:3] physNum,
   output logic [0:35] hostDataOut,
   output logic hostAck,
   output logic hostXfer,
   output logic hostIntrReq,
   output logic [2:0] hostIntrLevel,
   output logic mixSel1,
   output doorbell_pkg::bus_gates_s busGates,
   input wire doorbell_pkg::periph_reg_s periphReg,
   output logic [15:0] periphRdata,
   input wire logic periphGrant,
   input wire logic slaveSync,
   output logic periphBusRequest,
   output logic busBusyLine,
   output logic periphIntrLine,
   output logic [8:0] vectorOut,
   output logic [17:0] regBaseOut
);
   import doorbell_pkg::*;

   // slot wiring derived codes, latched after reset release
   logic [8:0] devCode_q;   // host device code
   logic [8:0] vector_q;    // peripheral vector
   logic [17:0] regBase_q;  // peripheral register base
   logic [3:0] physSel_q;   // physical controller number
   logic slotValid_q;       // wiring captured

   // request flags and channel
   logic periphReqFlag_q;   // host to peripheral doorbell
   logic hostReqFlag_q;     // peripheral to host doorbell
   logic piEnable_q;        // host interrupt enable
   logic [2:0] channel_q;   // host interrupt channel

   // decoded cycle terms
   logic devHit;      // device code match
   logic statWr;      // status write to us
   logic statRd;      // status read of us
   logic piServed;    // channel poll
   logic piAddrIn;    // interrupt word request
   logic anyHit;      // any answered cycle

   // peripheral port decode
   logic pWrStatus;
   logic setHostReq;
   logic clrPeriphReq;
   logic setPeriphReq;
   logic clrHostReq;

   // driver path
   logic [0:35] mixData;
   logic [0:35] driveComb;
   logic periphIntrReq;

   // device code of a slot: base plus a fixed step per slot
   function automatic logic [8:0] slot_dev_code(input logic [1:0] slot);
      slot_dev_code = `DEV_CODE_BASE + 9'(`DEV_CODE_STEP * slot);
   endfunction : slot_dev_code

   // vector of a slot: base minus a fixed step per slot
   function automatic logic [8:0] slot_vector(input logic [1:0] slot);
      slot_vector = `VEC_BASE - 9'(`VEC_STEP * slot);
   endfunction : slot_vector

   // [R13] capture slot wiring after reset
   // a strap level cannot load under asynchronous reset, so it is taken
   // on the first clock edge after release and held from then on
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         devCode_q <= 9'h000;
         vector_q <= 9'h000;
         regBase_q <= 18'h00000;
         physSel_q <= 4'h0;
         slotValid_q <= 1'b0;
      end else if (!slotValid_q) begin
         // [R07] device code per slot
         devCode_q <= slot_dev_code(slotNum);
         // [R12] vector and register base per slot
         vector_q <= slot_vector(slotNum);
         regBase_q <= `REGB_BASE + 18'(`REGB_STEP * slotNum);
         physSel_q <= physNum;
         slotValid_q <= 1'b1;
      end
   end

   // [R09] full device code on select lines
   // the low two bits of the code are always zero, so lines 00-06 carry bits 8-2
   assign devHit = slotValid_q && (hostCmd.sel == devCode_q[8:2]);

   // [R02] status write decode on host_cycle_strobe
   assign statWr = hostCmd.host_cycle_strobe && devHit && (hostCmd.func == `FN_STAT_WR);
   assign statRd = hostCmd.host_cycle_strobe && devHit && (hostCmd.func == `FN_STAT_RD);
   // [R08] interrupt dialogues: channel, then physical number for the interrupt word request only
   // ordinary cycles above use the device code alone
   assign piServed = hostCmd.host_cycle_strobe && slotValid_q && (hostCmd.func == `FN_PI_SERVED)
                   && (hostCmd.sel[4:6] == channel_q) && hostReqFlag_q;
   assign piAddrIn = hostCmd.host_cycle_strobe && slotValid_q && (hostCmd.func == `FN_PI_ADDR)
                   && (hostCmd.sel[4:6] == channel_q) && (hostCmd.sel[0:3] == physSel_q);
   assign anyHit = statWr | statRd | piServed | piAddrIn;

   // host status write side effects
   // [R01] bit 23 rings the peripheral
   assign setPeriphReq = statWr && hostDataIn[`HB_SET_PREQ];
   assign clrHostReq = statWr && hostDataIn[`HB_CLR_HREQ];

   // peripheral port decode
   assign pWrStatus = periphReg.wr && (periphReg.addr == `PREG_STATUS);
   assign setHostReq = pWrStatus && periphReg.wdata[`PB_SET_HREQ];
   assign clrPeriphReq = pWrStatus && periphReg.wdata[`PB_CLR_PREQ];

   // peripheral request flag
   // [R22] held until owner clears
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) periphReqFlag_q <= 1'b0;
      // [R03] strobe bit 23 into flag
      else if (setPeriphReq) periphReqFlag_q <= 1'b1;
      // [R19] peripheral clears with bit 10
      // a set in the same cycle wins so a doorbell is never lost
      else if (clrPeriphReq) periphReqFlag_q <= 1'b0;
   end

   // host request flag
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) hostReqFlag_q <= 1'b0;
      // [R20] peripheral bit 08 sets
      else if (setHostReq) hostReqFlag_q <= 1'b1;
      // [R21] host bit 26 clears
      else if (clrHostReq) hostReqFlag_q <= 1'b0;
   end

   // host interrupt enable and channel, loaded by every status write
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         piEnable_q <= 1'b0;
         channel_q <= `RST_CHAN;
      end else if (statWr) begin
         piEnable_q <= hostDataIn[`HB_PIEN];
         channel_q <= hostDataIn[`HB_PIA +: 3];
      end
   end

   // host interrupt line on the assigned channel
   assign hostIntrReq = hostReqFlag_q && piEnable_q && (channel_q != 3'h0);
   assign hostIntrLevel = channel_q;

   // [R10] mixer select one on status read only
   assign mixSel1 = statRd;

   // mixer contents for the current cycle
   always_comb begin
      mixData = '0;
      // [R11] status onto the mixed fields
      if (statRd) begin
         mixData[`ST_PREQ] = periphReqFlag_q;
         mixData[`ST_HREQ] = hostReqFlag_q;
         mixData[`HB_PIEN] = piEnable_q;
         mixData[`HB_PIA +: 3] = channel_q;
      end else if (piAddrIn) begin
         // interrupt word: function in 3-5, buffer fields 8-19, 23-25 and 28 through their gates, other mixed bits zero
         mixData[3:5] = `INTR_FUNC;
      end
   end

   // select gates and driver field mix
   bus_select_logic u_select (
      .busCtl(busCtl),
      .sendIntrWord(piAddrIn),
      .mix(mixData),
      .ebuf(ebufData),
      .gates(busGates),
      .driveOut(driveComb)
   );

   // host driver register, one cycle after host_cycle_strobe
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) hostDataOut <= '0;
      else hostDataOut <= driveComb;
   end

   // [R05] acknowledge and transfer pulse
   // both stand for the single cycle in which the driver holds the answer
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         hostAck <= 1'b0;
         hostXfer <= 1'b0;
      end else begin
         hostAck <= anyHit;
         hostXfer <= anyHit;
      end
   end

   // [R04] flag leaves as bus request
   assign periphIntrReq = periphReqFlag_q;

   // peripheral interrupt dialogue
   periph_intr_ctl u_intr (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .reqFlag(periphIntrReq),
      .grant(periphGrant),
      .slaveSync(slaveSync),
      .busRequest(periphBusRequest),
      .busBusy(busBusyLine),
      .intrLine(periphIntrLine)
   );

   // [R14] vector only while the line is up
   assign vectorOut = periphIntrLine ? vector_q : 9'h000;
   assign regBaseOut = regBase_q;

   // peripheral register read, data valid the cycle after the strobe
   // unmapped indices read zero; reads have no side effects
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) periphRdata <= `RST_RDATA;
      else if (periphReg.rd) begin
         case (periphReg.addr)
            `PREG_STATUS: begin
               periphRdata <= `RST_RDATA;
               periphRdata[`PB_SET_HREQ] <= hostReqFlag_q;
               periphRdata[`PB_CLR_PREQ] <= periphReqFlag_q;
            end
            `PREG_SLOT: periphRdata <= {7'h00, vector_q};
            default: periphRdata <= `RST_RDATA;
         endcase
      end else periphRdata <= `RST_RDATA;
   end

   // checks on the dialogue
   sequence s_ring_periph;
      statWr && hostDataIn[`HB_SET_PREQ];
   endsequence
   sequence s_ring_host;
      setHostReq;
   endsequence

   a_ring_sets_flag: assert property (@(posedge ref_clk) disable iff (!nrst) // [R03]
      s_ring_periph |=> periphReqFlag_q ##0 periphIntrReq) else $error("doorbell not set");
   a_flag_to_request: assert property (@(posedge ref_clk) disable iff (!nrst) // [R04]
      s_ring_periph |=> ##1 (periphBusRequest || busBusyLine)) else $error("no bus request");
   a_ack_after_write: assert property (@(posedge ref_clk) disable iff (!nrst) // [R05]
      statWr |=> hostAck && hostXfer ##1 (!hostAck || $past(anyHit)))
      else $error("ack not one pulse");
   a_host_flag_set: assert property (@(posedge ref_clk) disable iff (!nrst) // [R20]
      s_ring_host |=> hostReqFlag_q) else $error("host doorbell not set");
   a_host_flag_clear: assert property (@(posedge ref_clk) disable iff (!nrst) // [R21]
      clrHostReq && !setHostReq |=> !hostReqFlag_q) else $error("host flag not cleared");
   a_periph_clear: assert property (@(posedge ref_clk) disable iff (!nrst) // [R19]
      clrPeriphReq && !setPeriphReq |=> !periphReqFlag_q) else $error("flag not cleared");
   a_flags_hold: assert property (@(posedge ref_clk) disable iff (!nrst) // [R22]
      periphReqFlag_q && !clrPeriphReq |=> periphReqFlag_q) else $error("flag dropped");
   a_status_select: assert property (@(posedge ref_clk) disable iff (!nrst) // [R10]
      mixSel1 && !busCtl.dataDisable |=> hostDataOut[`ST_PREQ] == $past(periphReqFlag_q))
      else $error("status not routed by mixer select");
   a_status_fields: assert property (@(posedge ref_clk) disable iff (!nrst) // [R11]
      statRd && !busCtl.dataDisable |=> hostDataOut[`ST_HREQ] == $past(hostReqFlag_q))
      else $error("status field wrong");
   a_disable_zero: assert property (@(posedge ref_clk) disable iff (!nrst) // [R18]
      busCtl.dataDisable |=> hostDataOut == '0) else $error("driver live under disable");
   a_z_with_x: assert property (@(posedge ref_clk) disable iff (!nrst) // [R15]
      busGates.x || piAddrIn |-> busGates.z && (busGates.y || !busGates.x))
      else $error("z select missing");
   a_phys_only_intr: assert property (@(posedge ref_clk) disable iff (!nrst) // [R08]
      piAddrIn |-> hostCmd.sel[0:3] == physSel_q) else $error("physical number ignored");

endmodule : interprocessor_doorbell_dialogue

// file: common/doorbell_defs.svh
/*
 constants for the interprocessor doorbell block: slot wiring bases, function codes,
 host and peripheral bus bit positions, register indices and reset values.
 assumes host bus bit 0 is the most significant bit, as on the host bus itself.
*/
`ifndef DOORBELL_DEFS_SVH
`define DOORBELL_DEFS_SVH

// host device code of slot 0 (octal 200) and step per slot (octal 4)
`define DEV_CODE_BASE 9'h080
`define DEV_CODE_STEP 9'h004
// peripheral vector of slot 0 (octal 774), falling by octal 4 per slot
`define VEC_BASE 9'h1fc
`define VEC_STEP 9'h004
// peripheral register base of slot 0 (octal 774400), rising by octal 40 per slot
`define REGB_BASE 18'h3f900
`define REGB_STEP 18'h00020

// host function codes on function lines 00-02
`define FN_STAT_WR 3'h1
`define FN_STAT_RD 3'h5
`define FN_PI_SERVED 3'h6
`define FN_PI_ADDR 3'h7
// function field placed in the interrupt operation word (vector interrupt)
`define INTR_FUNC 3'h2

// host bus bit positions
`define HB_SET_PREQ 23
`define HB_CLR_HREQ 26
`define HB_PIEN 32
`define HB_PIA 33
`define ST_PREQ 22
`define ST_HREQ 26

// peripheral bus bit positions
`define PB_SET_HREQ 8
`define PB_CLR_PREQ 10

// peripheral register indices
`define PREG_STATUS 3'h0
`define PREG_SLOT 3'h1

// reset values
`define RST_CHAN 3'h0
`define RST_RDATA 16'h0000

`endif

// file: common/doorbell_pkg.sv
/*
 types shared by the doorbell block: host command carrier, bus control levels,
 bus select gates, peripheral register access and the interrupt states.
 assumes the defines header is compiled alongside for the numeric constants.
*/
package doorbell_pkg;

   // one host bus cycle as seen on select, function and host_cycle_strobe lines
   typedef struct packed {
      logic [0:6] sel;   // select lines 00-06
      logic [2:0] func;  // function lines 00-02
      logic host_cycle_strobe;      // host_cycle_strobe
   } host_cmd_s;

   // control levels from the transfer and diagnostic logic
   typedef struct packed {
      logic busLoopback;
      logic diagnosticSend;
      logic opwordSent;
      logic hostDataReadCycle;
      logic examineCycle;
      logic hostboundDataCycle;
      logic selA;
      logic dataDisable;
   } bus_ctl_s;

   // bus select gates toward the host drivers
   typedef struct packed {
      logic x;
      logic y;
      logic z;
      logic a;
   } bus_gates_s;

   // peripheral register port access
   typedef struct packed {
      logic [2:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } periph_reg_s;

   // peripheral interrupt dialogue
   typedef enum logic [1:0] {
      IR_IDLE,
      IR_REQUEST,
      IR_DRIVE,
      IR_RELEASE
   } intr_state_e;

endpackage : doorbell_pkg

// file: design/bus_select_logic.sv
/*
 bus select gates x, y, z and the host driver field mix.
 assumes all inputs are synchronous levels; outputs are combinational, driveOut is
 registered by the instantiating module, gates leave it unregistered.
*/
`timescale 1ns/100ps
module bus_select_logic (
   input wire doorbell_pkg::bus_ctl_s busCtl,
   input wire logic sendIntrWord,
   input wire logic [0:35] mix,
   input wire logic [0:35] ebuf,
   output doorbell_pkg::bus_gates_s gates,
   output logic [0:35] driveOut
);
   import doorbell_pkg::*;

   logic gx; // select x
   logic gz; // select z
   logic gy; // select y

   // [R16] x select terms
   assign gx = busCtl.busLoopback | busCtl.diagnosticSend
             | (busCtl.opwordSent & busCtl.hostDataReadCycle & busCtl.examineCycle);
   // [R15] z follows opword send or x
   assign gz = sendIntrWord | gx;
   // [R17] y follows x, a or hostbound data
   assign gy = gx | busCtl.selA | busCtl.hostboundDataCycle;
   assign gates = '{x: gx, y: gy, z: gz, a: busCtl.selA};

   // field mix; data disable forces every field low
   always_comb begin
      driveOut = '0;
      // [R18] data disable zeroes all
      if (!busCtl.dataDisable) begin
         driveOut[0:2] = mix[0:2];
         // [R15] z gates mixer 3-5, 7
         driveOut[3:5] = gz ? mix[3:5] : 3'h0;
         driveOut[6] = mix[6];
         driveOut[7] = gz & mix[7];
         driveOut[8:11] = gx ? ebuf[8:11] : 4'h0;
         driveOut[12:19] = busCtl.selA ? ebuf[12:19] : 8'h00;
         driveOut[20:22] = mix[20:22];
         // [R17] y gates buffer 23-25, 28
         driveOut[23:25] = gy ? ebuf[23:25] : 3'h0;
         driveOut[26:27] = mix[26:27];
         driveOut[28] = gy & ebuf[28];
         driveOut[29:35] = mix[29:35];
      end
   end

endmodule : bus_select_logic

// file: design/periph_intr_ctl.sv
/*
 peripheral side interrupt dialogue: bus request, bus busy, vector and
 interrupt line, released on slave sync.
 assumes grant and slave sync are synchronous levels from the peripheral bus.
*/
`timescale 1ns/100ps
module periph_intr_ctl (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic reqFlag,
   input wire logic grant,
   input wire logic slaveSync,
   output logic busRequest,
   output logic busBusy,
   output logic intrLine
);
   import doorbell_pkg::*;

   intr_state_e state_q;
   intr_state_e state_d;

   // next state; level request re-arms after each served dialogue
   always_comb begin
      state_d = state_q;
      case (state_q)
         IR_IDLE: if (reqFlag) state_d = IR_REQUEST;
         IR_REQUEST: begin
            // a flag cleared before grant withdraws the request
            if (!reqFlag) state_d = IR_IDLE;
            else if (grant) state_d = IR_DRIVE;
         end
         // [R14] slave sync ends the drive
         IR_DRIVE: if (slaveSync) state_d = IR_RELEASE;
         // wait for sync to fall so one answer is not counted twice
         IR_RELEASE: if (!slaveSync) state_d = IR_IDLE;
         default: state_d = IR_IDLE;
      endcase
   end

   // state register
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) state_q <= IR_IDLE;
      else state_q <= state_d;
   end

   // [R06] request while flag is pending, until grant
   assign busRequest = (state_q == IR_REQUEST);
   // [R14] busy, vector, line only while driving
   assign busBusy = (state_q == IR_DRIVE);
   assign intrLine = (state_q == IR_DRIVE);

   sequence s_driving;
      busBusy && intrLine;
   endsequence
   sequence s_answered;
      s_driving ##0 slaveSync;
   endsequence

   a_release_on_sync: assert property (@(posedge ref_clk) disable iff (!nrst) // [R14]
      s_answered |=> !busBusy && !intrLine) else $error("busy held after slave sync");
   a_request_follows_flag: assert property (@(posedge ref_clk) disable iff (!nrst) // [R06]
      (state_q == IR_IDLE) && reqFlag |=> busRequest) else $error("flag raised no request");

endmodule : periph_intr_ctl

// file: verification/periph_bus_model.sv
/*
 peripheral bus model: grants bus requests and answers the interrupt with slave sync.
 assumes one clock shared with the block; lag holds each answer back three cycles.
*/
`timescale 1ns/100ps
module periph_bus_model (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic lag,
   input wire logic busRequest,
   input wire logic intrLine,
   input wire logic [8:0] vector,
   output logic grant,
   output logic slaveSync,
   output logic [8:0] lastVec,
   output logic [7:0] nIntr
);
   logic [1:0] waitQ; // cycles spent on the pending step
   logic ready; // the pending step may be answered
   assign ready = !lag || waitQ == 2'h3;
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         waitQ <= 2'h0;
         grant <= 1'b0;
         slaveSync <= 1'b0;
         lastVec <= 9'h000;
         nIntr <= 8'h00;
      end else begin
         // count only while a step is pending, so each step lags anew
         if ((busRequest && !grant) || (intrLine && !slaveSync)) begin
            waitQ <= (waitQ == 2'h3) ? waitQ : waitQ + 2'h1;
         end else begin
            waitQ <= 2'h0;
         end
         grant <= busRequest && !intrLine && (grant || ready);
         // sync stays up until the line is dropped
         slaveSync <= intrLine && (slaveSync || ready);
         if (intrLine && ready && !slaveSync) begin
            lastVec <= vector;
            nIntr <= nIntr + 8'h01;
         end
      end
   end
endmodule : periph_bus_model

// file: verification/tb.sv
/*
 testbench of the doorbell block: host cycles, peripheral register port, interrupt
 dialogue for every slot, and bus select gating under random control levels.
 assumes the peripheral bus model stands on the far side of the interrupt pins.
*/
`timescale 1ns/100ps
`include "doorbell_defs.svh"
module tb;
   import doorbell_pkg::*;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   host_cmd_s hostCmd = '0;
   logic [0:35] hostDataIn = '0;
   logic [0:35] ebufData = '0;
   bus_ctl_s busCtl = '0;
   logic [1:0] slotNum = 2'h0;
   logic [0:3] physNum = 4'h0;
   periph_reg_s periphReg = '0;
   logic lag = 1'b0;
   logic [0:35] hostDataOut, w, q;
   logic hostAck, hostXfer, hostIntrReq, mixSel1, ack, mix, x, y;
   logic [2:0] hostIntrLevel, ch;
   bus_gates_s busGates;
   logic [15:0] periphRdata, rd;
   logic periphGrant, slaveSync, periphBusRequest, busBusyLine, periphIntrLine;
   logic [8:0] vectorOut, lastVec, vec, dcode;
   logic [17:0] regBaseOut;
   logic [7:0] nIntr, n0;
   bus_ctl_s c;
   integer seed = 26;
   integer errors = 0;
   integer nCompared = 0;

   always #50 ref_clk = ~ref_clk;

   interprocessor_doorbell_dialogue i_interprocessor_doorbell_dialogue (
      .ref_clk(ref_clk), .nrst(nrst), .hostCmd(hostCmd), .hostDataIn(hostDataIn),
      .ebufData(ebufData), .busCtl(busCtl), .slotNum(slotNum), .physNum(physNum),
      .hostDataOut(hostDataOut), .hostAck(hostAck), .hostXfer(hostXfer),
      .hostIntrReq(hostIntrReq), .hostIntrLevel(hostIntrLevel), .mixSel1(mixSel1),
      .busGates(busGates), .periphReg(periphReg), .periphRdata(periphRdata),
      .periphGrant(periphGrant), .slaveSync(slaveSync), .busBusyLine(busBusyLine),
      .periphBusRequest(periphBusRequest), .periphIntrLine(periphIntrLine),
      .vectorOut(vectorOut), .regBaseOut(regBaseOut));

   periph_bus_model i_periph_bus_model (
      .ref_clk(ref_clk), .nrst(nrst), .lag(lag), .busRequest(periphBusRequest),
      .intrLine(periphIntrLine), .vector(vectorOut), .grant(periphGrant),
      .slaveSync(slaveSync), .lastVec(lastVec), .nIntr(nIntr));

   task check(input logic [35:0] seen, input logic [35:0] exp);
      nCompared = nCompared + 1;
      if (seen !== exp) begin
         errors = errors + 1;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : check

   task tally_and_finish;
      if (errors == 0 && nCompared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : tally_and_finish

   // select, function and host_cycle_strobe driven in the same cycle
   // one host cycle: host_cycle_strobe for one cycle, answer sampled in the cycle after
   task host(input logic [6:0] s, input logic [2:0] f, input logic [0:35] d);
      @(posedge ref_clk);
      hostCmd <= '{sel: s, func: f, host_cycle_strobe: 1'b1};
      hostDataIn <= d;
      #1 mix = mixSel1;
      @(posedge ref_clk);
      hostCmd.host_cycle_strobe <= 1'b0;
      #1 ack = hostAck;
      q = hostDataOut;
   endtask : host

   // one peripheral register cycle, read data taken the cycle after
   task preg(input logic wr, input logic [2:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      periphReg <= '{addr: a, wdata: d, wr: wr, rd: !wr};
      @(posedge ref_clk);
      periphReg <= '0;
      #1 rd = periphRdata;
   endtask : preg

   // bounded wait for the next interrupt answered by the model
   task wait_intr;
      integer k;
      n0 = nIntr;
      k = 0;
      while (nIntr === n0 && k < 200) begin
         @(posedge ref_clk);
         #1 k = k + 1;
      end
      if (nIntr === n0) begin
         errors = errors + 1;
         tally_and_finish();
      end
   endtask : wait_intr

   // expected status read word
   function automatic logic [0:35] stat(logic p, logic h, logic [2:0] cn);
      logic [0:35] r;
      r = '0;
      r[`ST_PREQ] = p;
      r[`ST_HREQ] = h;
      r[`HB_PIEN] = 1'b1;
      r[33:35] = cn;
      return r;
   endfunction : stat

   initial begin
      for (int s = 0; s < 4; s++) begin
         nrst <= 1'b0;
         slotNum <= s[1:0];
         physNum <= 4'($random(seed));
         lag <= s[0];
         repeat (20) @(posedge ref_clk);
         nrst <= 1'b1;
         repeat (2) @(posedge ref_clk);
         dcode = `DEV_CODE_BASE + `DEV_CODE_STEP * s[8:0];
         vec = `VEC_BASE - `VEC_STEP * s[8:0];
         check(regBaseOut, `REGB_BASE + `REGB_STEP * s[17:0]);
         ch = 3'($random(seed));
         ch = ch | 3'h1;
         w = '0;
         w[`HB_SET_PREQ] = 1'b1;
         w[`HB_PIEN] = 1'b1;
         w[33:35] = ch;
         host(dcode[8:2] ^ 7'h01, `FN_STAT_WR, w);
         check(ack, 1'b0);
         host(dcode[8:2], 3'h3, w);
         check(ack, 1'b0);
         host(dcode[8:2], `FN_STAT_WR, w);
         check({ack, hostXfer, mix}, 3'h6);
         host(dcode[8:2], `FN_STAT_RD, '0);
         check({ack, mix}, 2'h3);
         check(q, stat(1'b1, 1'b0, ch));
         wait_intr();
         check(lastVec, vec);
         repeat (3) @(posedge ref_clk);
         #1 check({busBusyLine, periphIntrLine}, 2'h0);
         wait_intr();
         preg(1'b0, `PREG_STATUS, 16'h0000);
         check(rd, 16'h0400);
         preg(1'b1, `PREG_STATUS, 16'h0400);
         repeat (20) @(posedge ref_clk);
         #1 check({periphBusRequest, periphIntrLine}, 2'h0);
         host(dcode[8:2], `FN_STAT_RD, '0);
         check(q, stat(1'b0, 1'b0, ch));
         preg(1'b0, `PREG_SLOT, 16'h0000);
         check(rd, {7'h00, vec});
         preg(1'b1, `PREG_SLOT, 16'hffff);
         preg(1'b0, `PREG_SLOT, 16'h0000);
         check(rd, {7'h00, vec});
         preg(1'b0, 3'h5, 16'h0000);
         check(rd, 16'h0000);
         preg(1'b1, `PREG_STATUS, 16'h0100);
         check(hostIntrReq, 1'b1);
         host({physNum ^ 4'hf, ch}, `FN_PI_SERVED, '0);
         check(ack, 1'b1);
         host({physNum ^ 4'h1, ch}, `FN_PI_ADDR, '0);
         check(ack, 1'b0);
         host({physNum, ch}, `FN_PI_ADDR, '0);
         check(ack, 1'b1);
         host(dcode[8:2], `FN_STAT_RD, '0);
         check(q, stat(1'b0, 1'b1, ch));
         w = '0;
         w[`HB_CLR_HREQ] = 1'b1;
         w[`HB_PIEN] = 1'b1;
         w[33:35] = ch;
         host(dcode[8:2], `FN_STAT_WR, w);
         check({hostIntrReq, hostIntrLevel}, {1'b0, ch});
      end
      // random control levels against the select gates and driver fields
      for (int i = 0; i < 40; i++) begin
         c = 8'($random(seed));
         if (c.hostboundDataCycle) begin
            c.opwordSent = 1'b1;
         end
         w = {4'($random(seed)), 32'($random(seed))};
         x = c.busLoopback | c.diagnosticSend;
         x = x | (c.opwordSent & c.hostDataReadCycle & c.examineCycle);
         y = x | c.selA | c.hostboundDataCycle;
         @(posedge ref_clk);
         busCtl <= c;
         ebufData <= w;
         @(posedge ref_clk);
         #1 check({busGates.x, busGates.y, busGates.z, busGates.a}, {x, y, x, c.selA});
         if (c.dataDisable) begin
            check(hostDataOut, 36'h0);
         end else begin
            check({hostDataOut[23:25], hostDataOut[28]}, y ? {w[23:25], w[28]} : 4'h0);
         end
      end
      tally_and_finish();
   end
endmodule : tb
